// >>> design/loop_cfg_consts.vh
// register map, field positions and reset values of the loop configuration bank
`ifndef LOOP_CFG_CONSTS_VH
`define LOOP_CFG_CONSTS_VH

// register indices as printed; byte address is four times the index
`define IDX_DEN_TOP       8'h4E
`define IDX_DEN_MID       8'h4F
`define IDX_DEN_LOW       8'h50
`define IDX_MOD_CTRL      8'h51
`define IDX_RES_SECOND    8'h52
`define IDX_CAP_FIRST     8'h53
`define IDX_RES_THIRD     8'h54
`define IDX_STATUS        8'h60

`define RST_DEN_TOP       6'h00
`define RST_DEN_MID       8'h00
`define RST_DEN_LOW       8'h00
`define RST_DITHER        2'h3
`define RST_ORDER         2'h0
`define RST_RES_SECOND    6'h24
`define RST_CAP_FIRST     3'h0
`define RST_RES_THIRD     6'h00
`define RST_FRAC_SEL      1'h0

`define DITHER_HI         3
`define DITHER_LO         2
`define ORDER_HI          1
`define ORDER_LO          0
`define RES3_HI           6
`define RES3_LO           1
`define FRAC_SEL_BIT      0

`define ORDER_INTEGER     2'h0
`define DITHER_OFF        2'h3

// capacitance in pF: base plus step times code
`define CAP_BASE_PF       9'h005
`define CAP_STEP_PF       9'h032

`define AXI_OKAY          2'h0
`define AXI_SLVERR        2'h2

`endif

// >>> design/loop_cfg_axil_slave.v
// axi4-lite slave front end: accepts one write and one read at a time
`include "loop_cfg_consts.vh"
`default_nettype none

module loop_cfg_axil_slave #(
    parameter AW = 10
) (
    input  wire          clk,
    input  wire          rst,
    input  wire [AW-1:0] awaddr,
    input  wire          awvalid,
    output reg           awready,
    input  wire [31:0]   wdata,
    input  wire [3:0]    wstrb,
    input  wire          wvalid,
    output reg           wready,
    output reg  [1:0]    bresp,
    output reg           bvalid,
    input  wire          bready,
    input  wire [AW-1:0] araddr,
    input  wire          arvalid,
    output reg           arready,
    output reg  [31:0]   rdata,
    output reg  [1:0]    rresp,
    output reg           rvalid,
    input  wire          rready,
    output reg           wr_en,
    output reg  [AW-3:0] wr_idx,
    output reg  [7:0]    wr_byte,
    input  wire          wr_hit,
    output wire [AW-3:0] rd_idx,
    input  wire [7:0]    rd_byte,
    input  wire          rd_hit
);

////////////////////////////////////////////////////////////////////////////////
// write channel

reg          aw_held_r;
reg [AW-3:0] aw_idx_r;
reg          w_held_r;
reg [7:0]    w_byte_r;
reg          w_lane_r;

always @(posedge clk) begin
    wr_en <= 1'b0;
    if (rst) begin
        awready   <= 1'b0;
        wready    <= 1'b0;
        bvalid    <= 1'b0;
        bresp     <= `AXI_OKAY;
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        aw_idx_r  <= {(AW-2){1'b0}};
        w_byte_r  <= 8'h00;
        w_lane_r  <= 1'b0;
        wr_idx    <= {(AW-2){1'b0}};
        wr_byte   <= 8'h00;
    end else begin
        awready <= !aw_held_r && !bvalid && !awready;
        wready  <= !w_held_r && !bvalid && !wready;
        if (awvalid && awready) begin
            aw_held_r <= 1'b1;
            aw_idx_r  <= awaddr[AW-1:2];
            // decode sees this write's index before the response is formed
            wr_idx    <= awaddr[AW-1:2];
        end
        if (wvalid && wready) begin
            w_held_r <= 1'b1;
            w_byte_r <= wdata[7:0];
            w_lane_r <= wstrb[0];
        end
        if (aw_held_r && w_held_r && !bvalid) begin
            wr_en     <= w_lane_r;
            wr_idx    <= aw_idx_r;
            wr_byte   <= w_byte_r;
            bvalid    <= 1'b1;
            bresp     <= wr_hit ? `AXI_OKAY : `AXI_SLVERR;
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
        end
        if (bvalid && bready)
            bvalid <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// read channel

reg [AW-3:0] ar_idx_r;
reg          ar_held_r;

// read decode uses the held address so the data matches the request
assign rd_idx = ar_idx_r;

always @(posedge clk) begin
    if (rst) begin
        arready   <= 1'b0;
        rvalid    <= 1'b0;
        rdata     <= 32'h00000000;
        rresp     <= `AXI_OKAY;
        ar_idx_r  <= {(AW-2){1'b0}};
        ar_held_r <= 1'b0;
    end else begin
        arready <= !ar_held_r && !rvalid && !arready;
        if (arvalid && arready) begin
            ar_held_r <= 1'b1;
            ar_idx_r  <= araddr[AW-1:2];
        end
        if (ar_held_r && !rvalid) begin
            rvalid    <= 1'b1;
            rdata     <= {24'h000000, rd_hit ? rd_byte : 8'h00};
            rresp     <= rd_hit ? `AXI_OKAY : `AXI_SLVERR;
            ar_held_r <= 1'b0;
        end
        if (rvalid && rready)
            rvalid <= 1'b0;
    end
end

endmodule // loop_cfg_axil_slave

`default_nettype wire

// >>> design/loop_cfg_regs.v
// configuration register bank of the second synthesizer loop
//
// Function
// RULE1: read-write byte holds denominator bits 15..8, resets to zero.
// RULE2: read-write byte holds denominator bits 7..0, resets to zero.
// RULE3: denominator is 22 bits; top six bits in preceding register, three bytes joined.
// RULE4: dither strength at bits 3:2; weak, medium, strong, off; resets to 3.
// RULE5: modulator order at bits 1:0; integer, first, second, third; resets to 0.
// RULE6: second resistor code six bits at 5:0, resets to 0x24, top two reserved.
// RULE7: second resistor code maps to resistance; any code is accepted.
// RULE8: first capacitor code bits 2:0 resets zero; pF equals 5 plus 50 times code.
// RULE9: third resistor code six bits at 6:1, bit 7 reserved, resets zero.
// RULE10: third resistor code maps to resistance; any code is accepted.
// RULE11: software sets bit 0 to 0 for integer and 1 for fractional loop.
// RULE12: software keeps fraction select consistent with the order field.
`include "loop_cfg_consts.vh"
`default_nettype none

module loop_cfg_regs #(
    parameter AW = 10
) (
    input  wire          REF_CLK,
    input  wire          SYS_RST,
    input  wire [AW-1:0] S_AXI_AWADDR,
    input  wire          S_AXI_AWVALID,
    output wire          S_AXI_AWREADY,
    input  wire [31:0]   S_AXI_WDATA,
    input  wire [3:0]    S_AXI_WSTRB,
    input  wire          S_AXI_WVALID,
    output wire          S_AXI_WREADY,
    output wire [1:0]    S_AXI_BRESP,
    output wire          S_AXI_BVALID,
    input  wire          S_AXI_BREADY,
    input  wire [AW-1:0] S_AXI_ARADDR,
    input  wire          S_AXI_ARVALID,
    output wire          S_AXI_ARREADY,
    output wire [31:0]   S_AXI_RDATA,
    output wire [1:0]    S_AXI_RRESP,
    output wire          S_AXI_RVALID,
    input  wire          S_AXI_RREADY,
    output reg  [21:0]   FRACTIONAL_DENOMINATOR,
    output reg  [1:0]    DITHER_STRENGTH,
    output reg  [1:0]    MODULATOR_ORDER,
    output reg  [5:0]    SECOND_LOOP_RESISTOR_CODE,
    output reg  [2:0]    FIRST_LOOP_CAPACITOR_CODE,
    output reg  [8:0]    FIRST_LOOP_CAPACITOR_PF,
    output reg  [5:0]    THIRD_LOOP_RESISTOR_CODE,
    output reg           LOOP_FILTER_FRACTION_SELECT,
    output reg           DITHER_ACTIVE,
    output reg           FILTER_MISMATCH
);

////////////////////////////////////////////////////////////////////////////////
// bus front end

wire          wr_en;
wire [AW-3:0] wr_idx;
wire [7:0]    wr_byte;
wire [AW-3:0] rd_idx;
reg  [7:0]    rd_byte;
reg           rd_hit;
reg           wr_hit;

loop_cfg_axil_slave #(.AW(AW)) u_slave (
    .clk     (REF_CLK),
    .rst     (SYS_RST),
    .awaddr  (S_AXI_AWADDR),
    .awvalid (S_AXI_AWVALID),
    .awready (S_AXI_AWREADY),
    .wdata   (S_AXI_WDATA),
    .wstrb   (S_AXI_WSTRB),
    .wvalid  (S_AXI_WVALID),
    .wready  (S_AXI_WREADY),
    .bresp   (S_AXI_BRESP),
    .bvalid  (S_AXI_BVALID),
    .bready  (S_AXI_BREADY),
    .araddr  (S_AXI_ARADDR),
    .arvalid (S_AXI_ARVALID),
    .arready (S_AXI_ARREADY),
    .rdata   (S_AXI_RDATA),
    .rresp   (S_AXI_RRESP),
    .rvalid  (S_AXI_RVALID),
    .rready  (S_AXI_RREADY),
    .wr_en   (wr_en),
    .wr_idx  (wr_idx),
    .wr_byte (wr_byte),
    .wr_hit  (wr_hit),
    .rd_idx  (rd_idx),
    .rd_byte (rd_byte),
    .rd_hit  (rd_hit)
);

////////////////////////////////////////////////////////////////////////////////
// write decode: hit if the index names a writable register

always @* begin
    case (wr_idx)
        `IDX_DEN_TOP, `IDX_DEN_MID, `IDX_DEN_LOW, `IDX_MOD_CTRL,
        `IDX_RES_SECOND, `IDX_CAP_FIRST, `IDX_RES_THIRD: wr_hit = 1'b1;
        default: wr_hit = 1'b0;
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// register storage

always @(posedge REF_CLK) begin
    if (SYS_RST) begin
        FRACTIONAL_DENOMINATOR      <= {`RST_DEN_TOP, `RST_DEN_MID, `RST_DEN_LOW}; // RULE3
        DITHER_STRENGTH             <= `RST_DITHER;                                  // RULE4
        MODULATOR_ORDER             <= `RST_ORDER;                                   // RULE5
        SECOND_LOOP_RESISTOR_CODE   <= `RST_RES_SECOND;                              // RULE6
        FIRST_LOOP_CAPACITOR_CODE   <= `RST_CAP_FIRST;                               // RULE8
        THIRD_LOOP_RESISTOR_CODE    <= `RST_RES_THIRD;                               // RULE9
        LOOP_FILTER_FRACTION_SELECT <= `RST_FRAC_SEL;
    end else if (wr_en && wr_hit) begin
        case (wr_idx[7:0])
            `IDX_DEN_TOP:    FRACTIONAL_DENOMINATOR[21:16] <= wr_byte[5:0]; // RULE3
            `IDX_DEN_MID:    FRACTIONAL_DENOMINATOR[15:8]  <= wr_byte;      // RULE1
            `IDX_DEN_LOW:    FRACTIONAL_DENOMINATOR[7:0]   <= wr_byte;      // RULE2
            `IDX_MOD_CTRL: begin
                DITHER_STRENGTH <= wr_byte[`DITHER_HI:`DITHER_LO]; // RULE4
                MODULATOR_ORDER <= wr_byte[`ORDER_HI:`ORDER_LO];   // RULE5
            end
            // every code is stored; the resistance lookup lives in the analog loop
            `IDX_RES_SECOND: SECOND_LOOP_RESISTOR_CODE <= wr_byte[5:0]; // RULE7
            `IDX_CAP_FIRST:  FIRST_LOOP_CAPACITOR_CODE <= wr_byte[2:0]; // RULE8
            `IDX_RES_THIRD: begin
                THIRD_LOOP_RESISTOR_CODE    <= wr_byte[`RES3_HI:`RES3_LO]; // RULE10
                LOOP_FILTER_FRACTION_SELECT <= wr_byte[`FRAC_SEL_BIT];     // RULE11
            end
            default: ;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// derived state, registered from the stored fields

always @(posedge REF_CLK) begin
    if (SYS_RST) begin
        FIRST_LOOP_CAPACITOR_PF <= `CAP_BASE_PF;
        DITHER_ACTIVE           <= 1'b0;
        FILTER_MISMATCH         <= 1'b0;
    end else begin
        FIRST_LOOP_CAPACITOR_PF <= `CAP_BASE_PF
            + `CAP_STEP_PF * {6'h00, FIRST_LOOP_CAPACITOR_CODE}; // RULE8
        DITHER_ACTIVE   <= (DITHER_STRENGTH != `DITHER_OFF)
            && (MODULATOR_ORDER != `ORDER_INTEGER); // RULE4
        FILTER_MISMATCH <= LOOP_FILTER_FRACTION_SELECT
            != (MODULATOR_ORDER != `ORDER_INTEGER); // RULE12
    end
end

////////////////////////////////////////////////////////////////////////////////
// read mux; reserved bits read zero

always @* begin
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    case (rd_idx)
        `IDX_DEN_TOP:    rd_byte = {2'h0, FRACTIONAL_DENOMINATOR[21:16]};
        `IDX_DEN_MID:    rd_byte = FRACTIONAL_DENOMINATOR[15:8];  // RULE1
        `IDX_DEN_LOW:    rd_byte = FRACTIONAL_DENOMINATOR[7:0];   // RULE2
        `IDX_MOD_CTRL:   rd_byte = {4'h0, DITHER_STRENGTH, MODULATOR_ORDER};
        `IDX_RES_SECOND: rd_byte = {2'h0, SECOND_LOOP_RESISTOR_CODE}; // RULE6
        `IDX_CAP_FIRST:  rd_byte = {5'h00, FIRST_LOOP_CAPACITOR_CODE};
        `IDX_RES_THIRD:  rd_byte = {1'h0, THIRD_LOOP_RESISTOR_CODE,
                                    LOOP_FILTER_FRACTION_SELECT};  // RULE9
        `IDX_STATUS:     rd_byte = {6'h00, FILTER_MISMATCH, DITHER_ACTIVE};
        default:         rd_hit  = 1'b0;
    endcase
end

endmodule // loop_cfg_regs

`default_nettype wire

// >>> tb/loop_cfg_regs_props.sv
// assertion checker for the loop configuration register bank
`default_nettype none
module loop_cfg_regs_props (
    input wire logic        REF_CLK,
    input wire logic        SYS_RST,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_BREADY,
    input wire logic [1:0]  S_AXI_BRESP,
    input wire logic [21:0] FRACTIONAL_DENOMINATOR,
    input wire logic [1:0]  DITHER_STRENGTH,
    input wire logic [1:0]  MODULATOR_ORDER,
    input wire logic [5:0]  SECOND_LOOP_RESISTOR_CODE,
    input wire logic [2:0]  FIRST_LOOP_CAPACITOR_CODE,
    input wire logic [8:0]  FIRST_LOOP_CAPACITOR_PF,
    input wire logic [5:0]  THIRD_LOOP_RESISTOR_CODE,
    input wire logic        LOOP_FILTER_FRACTION_SELECT,
    input wire logic        DITHER_ACTIVE,
    input wire logic        FILTER_MISMATCH
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);
////////////////////////////////////////////////////////////////////////////////
    property p_rst; $past(SYS_RST) |-> DITHER_STRENGTH == 2'h3 && MODULATOR_ORDER == 2'h0
        && SECOND_LOOP_RESISTOR_CODE == 6'h24; endproperty
    a_rst: assert property (p_rst) else $error("field reset value wrong");
    property p_pf; !$past(SYS_RST) |-> FIRST_LOOP_CAPACITOR_PF ==
        9'h005 + 9'h032 * $past(FIRST_LOOP_CAPACITOR_CODE); endproperty
    a_pf: assert property (p_pf) else $error("capacitance wrong");
    property p_den; !$past(SYS_RST) && !$stable(FRACTIONAL_DENOMINATOR) |->
        $past(S_AXI_BVALID) && !$past(S_AXI_BVALID, 2); endproperty
    a_den: assert property (p_den) else $error("denominator moved");
    property p_r2; !$past(SYS_RST) && !$stable(SECOND_LOOP_RESISTOR_CODE) |->
        $past(S_AXI_BVALID) && !$past(S_AXI_BVALID, 2); endproperty
    a_r2: assert property (p_r2) else $error("second resistor moved");
    property p_r3; !$past(SYS_RST) && !$stable(THIRD_LOOP_RESISTOR_CODE) |->
        $past(S_AXI_BVALID) && !$past(S_AXI_BVALID, 2); endproperty
    a_r3: assert property (p_r3) else $error("third resistor moved");
    property p_dact; !$past(SYS_RST) |-> DITHER_ACTIVE ==
        ($past(DITHER_STRENGTH) != 2'h3 && $past(MODULATOR_ORDER) != 2'h0); endproperty
    a_dact: assert property (p_dact) else $error("dither flag wrong");
    property p_mis; !$past(SYS_RST) |-> FILTER_MISMATCH ==
        ($past(LOOP_FILTER_FRACTION_SELECT) != ($past(MODULATOR_ORDER) != 2'h0)); endproperty
    a_mis: assert property (p_mis) else $error("mismatch flag wrong");
    property p_bhold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    cover property (S_AXI_BVALID && S_AXI_BRESP == 2'h2);
    cover property (DITHER_ACTIVE && FILTER_MISMATCH);
    cover property (S_AXI_BVALID && !S_AXI_BREADY);
endmodule // loop_cfg_regs_props

bind loop_cfg_regs loop_cfg_regs_props u_props (.REF_CLK, .SYS_RST, .S_AXI_BVALID,
    .S_AXI_BREADY, .S_AXI_BRESP, .FRACTIONAL_DENOMINATOR, .DITHER_STRENGTH, .MODULATOR_ORDER,
    .SECOND_LOOP_RESISTOR_CODE, .FIRST_LOOP_CAPACITOR_CODE, .FIRST_LOOP_CAPACITOR_PF,
    .THIRD_LOOP_RESISTOR_CODE, .LOOP_FILTER_FRACTION_SELECT, .DITHER_ACTIVE, .FILTER_MISMATCH);
`default_nettype wire

// >>> tb/loop_cfg_regs_test.sv
// self-checking bench for the loop configuration register bank
`default_nettype none
module loop_cfg_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0;
    logic        rry = 1'b0, awr, wrd, bv, arr, rv, sel, dact, mis;
    logic [9:0]  awa = 10'h000, ara = 10'h000;
    logic [31:0] wd = 32'h00000000, rd;
    logic [3:0]  ws = 4'h0;
    logic [1:0]  br, rr, dth, ord;
    logic [21:0] den;
    logic [5:0]  r2, r3;
    logic [2:0]  c1;
    logic [8:0]  pf;
    logic [7:0]  msk [7] = '{8'h3F, 8'hFF, 8'hFF, 8'h0F, 8'h3F, 8'h07, 8'h7F};
    logic [7:0]  ini [7] = '{8'h00, 8'h00, 8'h00, 8'h0C, 8'h24, 8'h00, 8'h00};
    logic [7:0]  cod [8] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h30};
    logic [33:0] rq [$];
    logic [1:0]  bq [$];
    int          n_errors = 0, checks_done = 0, seed = 68038;

    loop_cfg_regs #(.AW(10)) dut (
        .REF_CLK(clk), .SYS_RST(rst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
        .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(wrd), .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
        .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd),
        .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry),
        .FRACTIONAL_DENOMINATOR(den), .DITHER_STRENGTH(dth), .MODULATOR_ORDER(ord),
        .SECOND_LOOP_RESISTOR_CODE(r2), .FIRST_LOOP_CAPACITOR_CODE(c1),
        .FIRST_LOOP_CAPACITOR_PF(pf), .THIRD_LOOP_RESISTOR_CODE(r3),
        .LOOP_FILTER_FRACTION_SELECT(sel), .DITHER_ACTIVE(dact), .FILTER_MISMATCH(mis));

    always #2.5 clk = ~clk;
////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic bus_wr(input logic [7:0] i, d, input logic [3:0] s, input logic [1:0] e);
        logic a, w;
        a = 1'b0;
        w = 1'b0;
        bq.push_back(e);
        @(posedge clk);
        awa <= {i, 2'b00};
        wd <= {24'($random(seed)), d};
        ws <= s;
        awv <= 1'b1;
        wv <= 1'b1;
        while (!(a && w)) begin
            @(posedge clk);
            a = a | (awr === 1'b1);
            w = w | (wrd === 1'b1);
            awv <= !a;
            wv <= !w;
        end
        // late bready so the response has to stand
        repeat (2) @(posedge clk);
        bry <= 1'b1;
        do @(posedge clk); while (bv !== 1'b1);
        bry <= 1'b0;
    endtask

    task automatic bus_rd(input logic [7:0] i, d, input logic [1:0] e);
        rq.push_back({e, 24'h000000, d});
        @(posedge clk);
        ara <= {i, 2'b00};
        arv <= 1'b1;
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 1'b0;
        rry <= 1'b1;
        do @(posedge clk); while (rv !== 1'b1);
        rry <= 1'b0;
    endtask

    task automatic reset_check;
        for (int j = 0; j < 7; j++) bus_rd(8'h4E + 8'(j), ini[j], 2'h0);
        #1;
        chk("pf", 9'h005, pf);
    endtask

    task automatic test_done;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    always @(posedge clk) begin
        if (bv === 1'b1 && bry) chk("bresp", bq.pop_front(), br);
        if (rv === 1'b1 && rry) chk("rdata", rq.pop_front(), {rr, rd});
    end

    // about eighteen times the expected run
    initial begin
        #50000;
        n_errors++;
        test_done();
    end

    initial begin
        logic [7:0] v [7];
        logic [3:0] k;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        reset_check();
        for (int j = 0; j < 7; j++) begin
            v[j] = 8'($random(seed));
            bus_wr(8'h4E + 8'(j), v[j], 4'hF, 2'h0);
            bus_rd(8'h4E + 8'(j), v[j] & msk[j], 2'h0);
        end
        #1;
        chk("den", {v[0][5:0], v[1], v[2]}, den);
        chk("r3", v[6][6:1], r3);
        chk("sel", v[6][0], sel);
        for (int j = 0; j < 16; j++) begin
            k = 4'(j);
            bus_wr(8'h51, {4'h0, k}, 4'hF, 2'h0);
            bus_wr(8'h53, {5'h00, k[2:0]}, 4'hF, 2'h0);
            bus_wr(8'h54, {7'h00, k[2]}, 4'hF, 2'h0);
            #1;
            chk("dither", k[3:2], dth);
            chk("order", k[1:0], ord);
            chk("pf", 9'h005 + 9'h032 * k[2:0], pf);
            chk("active", k[3:2] != 2'h3 && k[1:0] != 2'h0, dact);
            chk("mismatch", k[2] != (k[1:0] != 2'h0), mis);
            chk("c1", k[2:0], c1);
            bus_rd(8'h60, {6'h00, k[2] != (k[1:0] != 2'h0),
                           k[3:2] != 2'h3 && k[1:0] != 2'h0}, 2'h0);
        end
        foreach (cod[j]) begin
            bus_wr(8'h52, cod[j], 4'hF, 2'h0);
            bus_wr(8'h54, {cod[j][6:0], 1'b1}, 4'hF, 2'h0);
            #1;
            chk("r2", cod[j][5:0], r2);
            chk("r3", cod[j][5:0], r3);
        end
        bus_wr(8'h55, 8'hFF, 4'hF, 2'h2);
        bus_rd(8'h55, 8'h00, 2'h2);
        bus_wr(8'h60, 8'hFF, 4'hF, 2'h2);
        bus_wr(8'h4F, ~v[1], 4'hE, 2'h0);
        bus_rd(8'h4F, v[1], 2'h0);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        reset_check();
        repeat (4) @(posedge clk);
        test_done();
    end
endmodule // loop_cfg_regs_test
`default_nettype wire
